// File: logic/srr_consts.svh
// constants of the status read responder: frame ids, offsets, fields, flags
`ifndef SRR_CONSTS_SVH
`define SRR_CONSTS_SVH

// ----------------------------------------------------------------
// frame identifiers, command code and broadcast node address
// ----------------------------------------------------------------
`define SRR_ID_CMD       6'h01
`define SRR_ID_GROUP     6'h02
`define SRR_ID_FULL      6'h07
`define SRR_ID_OTP       6'h08
`define SRR_ID_QUICK     6'h09
`define SRR_ID_BEMF      6'h0A
`define SRR_CMD_SAFE     8'h04
`define SRR_NAD_BCAST    8'h7F

// ----------------------------------------------------------------
// apb register offsets, reset value and write masks
// ----------------------------------------------------------------
`define SRR_A_CFG0       8'h00
`define SRR_A_CFG1       8'h04
`define SRR_A_CFG2       8'h08
`define SRR_A_CFG3       8'h0C
`define SRR_A_FLAGS      8'h10
`define SRR_CFG_RST      32'h0000_0000
`define SRR_M_CFG0       32'h0000_FFFF
`define SRR_M_CFG1       32'h000F_FFFF
`define SRR_M_CFG2       32'h001F_FF7F
`define SRR_M_CFG3       32'h0000_01FF

// ----------------------------------------------------------------
// configuration fields
// ----------------------------------------------------------------
`define SRR_C0_IHOLD     3:0
`define SRR_C0_IRUN      7:4
`define SRR_C0_MIN_VELOCITY_CODE      11:8
`define SRR_C0_MAX_VELOCITY_CODE      15:12
`define SRR_C1_ACC       3:0
`define SRR_C1_ABSOLUTE_THRESHOLD    7:4
`define SRR_C1_THIRD_SUPPLY_LOW_THRESHOLD    10:8
`define SRR_C1_STEPRES   12:11
`define SRR_C1_TSTAB     15:13
`define SRR_C1_PWMF      16
`define SRR_C1_BOOSTDIS  17
`define SRR_C1_SHAFT     18
`define SRR_C1_ACCELERATION_PROFILE_SELECT  19
`define SRR_C2_NODE      6:0
`define SRR_C2_SAFEPOS   18:8
`define SRR_C2_ALTSEL    19
`define SRR_C2_SAFEEN    20
`define SRR_C3_MINS      3:0
`define SRR_C3_JITTER    4
`define SRR_C3_DC100EN   5
`define SRR_C3_FS2EN     8:6

// ----------------------------------------------------------------
// sticky flag indices and clear masks
// ----------------------------------------------------------------
`define SRR_NFLAG        18
`define SRR_F_TW         0
`define SRR_F_TSD        1
`define SRR_F_UV         2
`define SRR_F_UV2        3
`define SRR_F_UV3        4
`define SRR_F_LOST_STEPS_FLAG   5
`define SRR_F_COIL_X_OVERCURRENT       6
`define SRR_F_COIL_Y_OVERCURRENT       7
`define SRR_F_VDDRST     8
`define SRR_F_BUSERR     9
`define SRR_F_DATA_ERROR_FLAG      10
`define SRR_F_BIT_ERROR_FLAG       11
`define SRR_F_HEADER_ERROR      12
`define SRR_F_BUS_TIMEOUT_ERROR      13
`define SRR_F_STALL      14
`define SRR_F_LATCHED_BLOCKED_ROTOR_FLAG   15
`define SRR_F_ELOPEN     16
`define SRR_F_ELSHORT    17
`define SRR_CLR_FULL1    18'h33FFF
`define SRR_CLR_FULL2    18'h0C000
`define SRR_CLR_QUICK    18'h1003F

`endif

// File: logic/srr_pkg.sv
// types of the status read responder
package srr_pkg;
   typedef enum logic [0:0] {
      SRR_IDLE = 1'b0,
      SRR_SEND = 1'b1
   } srr_state_type;
   typedef logic [7:0] srr_byte_type;
endpackage

// File: logic/srr_status_read_responder.sv
// status, otp and back-emf reads plus move-to-safe command decode
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ps
`include "srr_consts.svh"

module srr_status_read_responder
   import srr_pkg::*;
(
   input  wire logic                  sys_clk,
   input  wire logic                  rstn,
   // apb slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [7:0]            paddr,
   input  wire logic [31:0]           pwdata,
   output logic                       pready,
   output logic [31:0]                prdata,
   output logic                       pslverr,
   // frame engine: header, received bytes, transmitted bytes
   input  wire logic                  hdrValid,
   input  wire logic [7:0]            hdrPid,
   input  wire logic                  rxValid,
   input  wire logic [7:0]            rxData,
   input  wire logic                  rxLast,
   input  wire logic                  txReady,
   output logic                       txValid,
   output logic [7:0]                 txData,
   output logic                       txLast,
   // flag causes (levels) and live state
   input  wire logic [`SRR_NFLAG-1:0] flagCause,
   input  wire logic [2:0]            motionState,
   input  wire logic                  externalSwitchState,
   input  wire logic [1:0]            temperatureInfo,
   input  wire logic                  fullDutyFlag,
   input  wire logic [15:0]           actualPosition,
   input  wire logic [15:0]           targetPosition,
   input  wire logic [79:0]           otpBytes,
   input  wire logic                  backemfFullDutyFlag,
   input  wire logic                  backemfCoil,
   input  wire logic [4:0]            backemfValue,
   // internal safe-move triggers and priority veto
   input  wire logic                  safeMoveRequest,
   input  wire logic                  safeMoveIgnore,
   output logic                       safeMoveStart,
   output logic [10:0]                safeMoveTarget
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [31:0]             cfg0_r, cfg0_nxt, cfg1_r, cfg1_nxt;
   logic [31:0]             cfg2_r, cfg2_nxt, cfg3_r, cfg3_nxt;
   logic                    pready_r, pready_nxt, pslverr_r, pslverr_nxt;
   logic [31:0]             prdata_r, prdata_nxt;
   logic [`SRR_NFLAG-1:0]   flag_r, flag_nxt, flagClr;
   srr_state_type           state_r, state_nxt;
   srr_byte_type            buf_r [0:7];
   srr_byte_type            buf_nxt [0:7];
   logic [3:0]              len_r, len_nxt, idx_r, idx_nxt;
   logic [7:0]              sum_r, sum_nxt;
   logic [17:0]             pendClr_r, pendClr_nxt;
   logic                    seq_r, seq_nxt;
   logic [5:0]              curId_r, curId_nxt;
   logic [1:0]              rxCnt_r, rxCnt_nxt;
   logic [7:0]              rxNad_r, rxNad_nxt;
   logic                    txValid_r, txValid_nxt, txLast_r, txLast_nxt;
   logic [7:0]              txData_r, txData_nxt;
   logic                    safeStart_r, safeStart_nxt;
   logic [10:0]             safeTgt_r, safeTgt_nxt;
   logic [7:0]              quickByte;
   logic                    apbSetup, cmdHit;
   logic                    electrical_defect_flag;

   // enhanced checksum step: add with end-around carry
   function automatic logic [7:0] csumAdd(input logic [7:0] a,
                                          input logic [7:0] b);
      logic [8:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[7:0] + {7'h00, s[8]};
   endfunction

   // decodes an apb offset to a readable word, used for read data
   function automatic logic [32:0] regRead(input logic [7:0] a,
                                           input logic [31:0] c0,
                                           input logic [31:0] c1,
                                           input logic [31:0] c2,
                                           input logic [31:0] c3,
                                           input logic [17:0] f);
      logic [32:0] r;
      r = 33'h0_0000_0000;
      unique case (a)
         `SRR_A_CFG0:  r = {1'b1, c0};
         `SRR_A_CFG1:  r = {1'b1, c1};
         `SRR_A_CFG2:  r = {1'b1, c2};
         `SRR_A_CFG3:  r = {1'b1, c3};
         `SRR_A_FLAGS: r = {1'b1, 14'h0000, f};
         default:      r = 33'h0_0000_0000;
      endcase
      return r;
   endfunction

   // ----------------------------------------------------------------
   // apb slave: zero-wait access, unmapped offset gives pslverr
   // ----------------------------------------------------------------
   assign apbSetup = psel & ~penable;

   always_comb begin
      logic [32:0] rd;
      rd          = regRead(paddr, cfg0_r, cfg1_r, cfg2_r, cfg3_r, flag_r);
      pready_nxt  = apbSetup;
      pslverr_nxt = apbSetup & ~rd[32];
      prdata_nxt  = (apbSetup & ~pwrite) ? rd[31:0] : 32'h0000_0000;
      cfg0_nxt    = cfg0_r;
      cfg1_nxt    = cfg1_r;
      cfg2_nxt    = cfg2_r;
      cfg3_nxt    = cfg3_r;
      // writes land in the access cycle, the one pready is high in
      if (psel & penable & pready_r & pwrite) begin
         unique case (paddr)
            `SRR_A_CFG0: cfg0_nxt = pwdata & `SRR_M_CFG0;
            `SRR_A_CFG1: cfg1_nxt = pwdata & `SRR_M_CFG1;
            `SRR_A_CFG2: cfg2_nxt = pwdata & `SRR_M_CFG2;
            `SRR_A_CFG3: cfg3_nxt = pwdata & `SRR_M_CFG3;
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cfg0_r    <= `SRR_CFG_RST;
         cfg1_r    <= `SRR_CFG_RST;
         cfg2_r    <= `SRR_CFG_RST;
         cfg3_r    <= `SRR_CFG_RST;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
      end else begin
         cfg0_r    <= cfg0_nxt;
         cfg1_r    <= cfg1_nxt;
         cfg2_r    <= cfg2_nxt;
         cfg3_r    <= cfg3_nxt;
         pready_r  <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         prdata_r  <= prdata_nxt;
      end
   end

   // ----------------------------------------------------------------
   // sticky flags: a live cause always wins over a clear
   // ----------------------------------------------------------------
   always_comb begin
      flag_nxt = flagCause | (flag_r & ~flagClr);
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         flag_r <= {`SRR_NFLAG{1'b0}};
      end else begin
         flag_r <= flag_nxt;
      end
   end

   // short and open coil are kept apart so the quick read clears only open
   assign electrical_defect_flag = flag_r[`SRR_F_ELOPEN] | flag_r[`SRR_F_ELSHORT];

   // quick status byte, shared by full status and quick read
   assign quickByte = {externalSwitchState, flag_r[`SRR_F_LOST_STEPS_FLAG], electrical_defect_flag,
                       flag_r[`SRR_F_UV], flag_r[`SRR_F_TSD],
                       flag_r[`SRR_F_TW], temperatureInfo};

   // ----------------------------------------------------------------
   // responder and command decoder
   // ----------------------------------------------------------------
   always_comb begin
      state_nxt     = state_r;
      len_nxt       = len_r;
      idx_nxt       = idx_r;
      sum_nxt       = sum_r;
      pendClr_nxt   = pendClr_r;
      seq_nxt       = seq_r;
      curId_nxt     = curId_r;
      rxCnt_nxt     = rxCnt_r;
      rxNad_nxt     = rxNad_r;
      txValid_nxt   = txValid_r;
      txData_nxt    = txData_r;
      txLast_nxt    = txLast_r;
      safeStart_nxt = 1'b0;
      safeTgt_nxt   = safeTgt_r;
      flagClr       = 18'h00000;
      cmdHit        = 1'b0;
      for (int i = 0; i < 8; i++) begin
         buf_nxt[i] = buf_r[i];
      end

      // header: a new frame starts; headers are ignored while sending
      if (hdrValid && state_r == SRR_IDLE) begin
         curId_nxt = hdrPid[5:0];
         rxCnt_nxt = 2'd0;
         sum_nxt   = hdrPid;
         idx_nxt   = 4'd0;
         // any other frame ends an open full-status pair
         if (hdrPid[5:0] != `SRR_ID_FULL) begin
            seq_nxt = 1'b0;
         end
         unique case (hdrPid[5:0])
            `SRR_ID_FULL: begin
               state_nxt  = SRR_SEND;
               len_nxt    = 4'd8;
               buf_nxt[0] = {seq_r, cfg2_r[`SRR_C2_NODE]};
               if (!seq_r) begin
                  buf_nxt[1] = {cfg0_r[`SRR_C0_IRUN],
                                cfg0_r[`SRR_C0_IHOLD]};
                  buf_nxt[2] = {cfg0_r[`SRR_C0_MAX_VELOCITY_CODE],
                                cfg0_r[`SRR_C0_MIN_VELOCITY_CODE]};
                  buf_nxt[3] = {cfg1_r[`SRR_C1_ABSOLUTE_THRESHOLD],
                                cfg1_r[`SRR_C1_ACC]};
                  buf_nxt[4] = {cfg1_r[`SRR_C1_TSTAB],
                                cfg1_r[`SRR_C1_STEPRES],
                                cfg1_r[`SRR_C1_THIRD_SUPPLY_LOW_THRESHOLD]};
                  buf_nxt[5] = {cfg1_r[`SRR_C1_ACCELERATION_PROFILE_SELECT],
                                cfg1_r[`SRR_C1_SHAFT],
                                cfg1_r[`SRR_C1_BOOSTDIS],
                                cfg1_r[`SRR_C1_PWMF],
                                flag_r[`SRR_F_BUS_TIMEOUT_ERROR],
                                flag_r[`SRR_F_HEADER_ERROR],
                                flag_r[`SRR_F_COIL_X_OVERCURRENT],
                                flag_r[`SRR_F_COIL_Y_OVERCURRENT]};
                  buf_nxt[6] = {motionState, flag_r[`SRR_F_STALL],
                                flag_r[`SRR_F_BUSERR],
                                flag_r[`SRR_F_UV2], flag_r[`SRR_F_UV3],
                                flag_r[`SRR_F_VDDRST]};
                  buf_nxt[7] = quickByte;
                  pendClr_nxt = `SRR_CLR_FULL1;
               end else begin
                  buf_nxt[1] = actualPosition[7:0];
                  buf_nxt[2] = actualPosition[15:8];
                  buf_nxt[3] = targetPosition[7:0];
                  buf_nxt[4] = targetPosition[15:8];
                  buf_nxt[5] = cfg2_r[15:8];
                  buf_nxt[6] = {cfg3_r[`SRR_C3_FS2EN],
                                cfg3_r[`SRR_C3_DC100EN],
                                flag_r[`SRR_F_BUSERR],
                                cfg2_r[18:16]};
                  buf_nxt[7] = {flag_r[`SRR_F_LATCHED_BLOCKED_ROTOR_FLAG], 1'b1,
                                cfg3_r[`SRR_C3_JITTER], fullDutyFlag,
                                cfg3_r[`SRR_C3_MINS]};
                  pendClr_nxt = `SRR_CLR_FULL2;
               end
            end
            `SRR_ID_OTP: begin
               state_nxt = SRR_SEND;
               len_nxt   = 4'd8;
               for (int i = 0; i < 8; i++) begin
                  buf_nxt[i] = otpBytes[8*i +: 8];
               end
               if (cfg2_r[`SRR_C2_ALTSEL]) begin
                  buf_nxt[5] = otpBytes[64 +: 8];
                  buf_nxt[6] = otpBytes[72 +: 8];
               end
               pendClr_nxt = 18'h00000;
            end
            `SRR_ID_QUICK: begin
               state_nxt   = SRR_SEND;
               len_nxt     = 4'd1;
               buf_nxt[0]  = quickByte;
               pendClr_nxt = `SRR_CLR_QUICK;
            end
            `SRR_ID_BEMF: begin
               state_nxt   = SRR_SEND;
               len_nxt     = 4'd1;
               buf_nxt[0]  = {1'b1, backemfFullDutyFlag, backemfCoil,
                              backemfValue};
               pendClr_nxt = 18'h00000;
            end
            default: ;
         endcase
         if (state_nxt == SRR_SEND) begin
            txValid_nxt = 1'b1;
            txData_nxt  = buf_nxt[0];
            txLast_nxt  = 1'b0;
         end
      end

      // byte stream out, checksum byte last
      if (state_r == SRR_SEND && txValid_r && txReady) begin
         if (txLast_r) begin
            state_nxt   = SRR_IDLE;
            txValid_nxt = 1'b0;
            txLast_nxt  = 1'b0;
            flagClr     = pendClr_r;
            if (curId_r == `SRR_ID_FULL) begin
               seq_nxt = ~seq_r;
            end
         end else if (idx_r + 4'd1 == len_r) begin
            txData_nxt = ~csumAdd(sum_r, txData_r);
            txLast_nxt = 1'b1;
         end else begin
            sum_nxt    = csumAdd(sum_r, txData_r);
            idx_nxt    = idx_r + 4'd1;
            txData_nxt = buf_r[idx_r[2:0] + 3'd1];
         end
         if (!txLast_r && idx_r + 4'd1 == len_r) begin
            sum_nxt = csumAdd(sum_r, txData_r);
         end
      end

      // command frames: id 1 carries node address, id 2 is group-wide
      if (rxValid && state_r == SRR_IDLE) begin
         if (rxCnt_r != 2'd3) begin
            rxCnt_nxt = rxCnt_r + 2'd1;
         end
         if (rxCnt_r == 2'd0) begin
            rxNad_nxt = rxData;
         end
         if (curId_r == `SRR_ID_CMD && rxCnt_r == 2'd1) begin
            cmdHit = (rxData == `SRR_CMD_SAFE) &&
                     (rxNad_r == {1'b0, cfg2_r[`SRR_C2_NODE]} ||
                      rxNad_r == `SRR_NAD_BCAST);
         end
         if (curId_r == `SRR_ID_GROUP && rxCnt_r == 2'd0) begin
            cmdHit = rxData == `SRR_CMD_SAFE;
         end
         if (rxLast) begin
            rxCnt_nxt = 2'd3;
         end
      end

      // safe move, bus command or internal trigger, enable not consulted
      if ((cmdHit || safeMoveRequest) && !safeMoveIgnore) begin
         safeStart_nxt = 1'b1;
         safeTgt_nxt   = cfg2_r[`SRR_C2_SAFEPOS];
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state_r     <= SRR_IDLE;
         len_r       <= 4'd0;
         idx_r       <= 4'd0;
         sum_r       <= 8'h00;
         pendClr_r   <= 18'h00000;
         seq_r       <= 1'b0;
         curId_r     <= 6'h00;
         rxCnt_r     <= 2'd3;
         rxNad_r     <= 8'h00;
         txValid_r   <= 1'b0;
         txData_r    <= 8'h00;
         txLast_r    <= 1'b0;
         safeStart_r <= 1'b0;
         safeTgt_r   <= 11'h000;
         for (int i = 0; i < 8; i++) begin
            buf_r[i] <= 8'h00;
         end
      end else begin
         state_r     <= state_nxt;
         len_r       <= len_nxt;
         idx_r       <= idx_nxt;
         sum_r       <= sum_nxt;
         pendClr_r   <= pendClr_nxt;
         seq_r       <= seq_nxt;
         curId_r     <= curId_nxt;
         rxCnt_r     <= rxCnt_nxt;
         rxNad_r     <= rxNad_nxt;
         txValid_r   <= txValid_nxt;
         txData_r    <= txData_nxt;
         txLast_r    <= txLast_nxt;
         safeStart_r <= safeStart_nxt;
         safeTgt_r   <= safeTgt_nxt;
         for (int i = 0; i < 8; i++) begin
            buf_r[i] <= buf_nxt[i];
         end
      end
   end

   // ----------------------------------------------------------------
   // outputs, all from flip-flops
   // ----------------------------------------------------------------
   assign pready         = pready_r;
   assign prdata         = prdata_r;
   assign pslverr        = pslverr_r;
   assign txValid        = txValid_r;
   assign txData         = txData_r;
   assign txLast         = txLast_r;
   assign safeMoveStart  = safeStart_r;
   assign safeMoveTarget = safeTgt_r;

endmodule

// File: dv/srr_monitor.sv
// assertion checker on the status read responder ports
`timescale 1ns/1ps

module srr_monitor (
   input  wire logic       sys_clk,
   input  wire logic       rstn,
   input  wire logic       psel,
   input  wire logic       penable,
   input  wire logic       pready,
   input  wire logic       pslverr,
   input  wire logic       hdrValid,
   input  wire logic       txReady,
   input  wire logic       txValid,
   input  wire logic       txLast,
   input  wire logic [7:0] hdrPid,
   input  wire logic [7:0] txData,
   input  wire logic       safeMoveRequest,
   input  wire logic       safeMoveIgnore,
   input  wire logic       safeMoveStart
);
   // ----------------------------------------------------------
   // bus, response and safe-move relations
   // ----------------------------------------------------------
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   a_apb_ready: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held too long");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_byte_hold: assert property (txValid && !txReady |=> txValid
      && $stable(txData) && $stable(txLast))
      else $error("response byte changed while stalled");
   a_last_valid: assert property (txLast |-> txValid)
      else $error("checksum marker without valid");
   a_last_gap: assert property (txValid && txReady && txLast |=> !txValid)
      else $error("no gap after checksum");
   a_quick_ans: assert property (hdrValid && hdrPid[5:0] == 6'h09 &&
      !txValid |=> txValid && !txLast)
      else $error("quick status not answered");
   a_safe_req: assert property (safeMoveRequest && !safeMoveIgnore
      |=> safeMoveStart)
      else $error("internal safe move lost");
   a_safe_veto: assert property (safeMoveStart |-> !$past(safeMoveIgnore))
      else $error("safe move despite veto");
endmodule

// File: dv/srr_lin_master.sv
// bus master model: headers, command bytes, response collection
`timescale 1ns/1ps

module srr_lin_master (
   input  wire logic       sys_clk,
   input  wire logic       txValid,
   input  wire logic [7:0] txData,
   input  wire logic       txLast,
   output logic            hdrValid = 1'b0,
   output logic [7:0]      hdrPid = 8'h00,
   output logic            rxValid = 1'b0,
   output logic [7:0]      rxData = 8'h00,
   output logic            rxLast = 1'b0,
   output logic            txReady = 1'b0
);
   logic [7:0] got [0:8];
   int         nGot;
   // ----------------------------------------------------------
   // header plus command bytes; idle data shows the inverse
   // ----------------------------------------------------------
   task automatic send(input logic [7:0] pid, input logic [15:0] b,
                       input int n);
      @(posedge sys_clk);
      hdrValid <= 1'b1;
      hdrPid   <= pid;
      for (int i = 0; i < n; i++) begin
         @(posedge sys_clk);
         hdrValid <= 1'b0;
         rxValid  <= 1'b1;
         rxData   <= b[15-8*i -: 8];
         rxLast   <= (i == n - 1);
      end
      @(posedge sys_clk);
      {hdrValid, rxValid, rxLast} <= 3'b000;
      rxData <= ~rxData;
   endtask
   // slow mode stalls every other cycle, as a busy engine would
   task automatic collect(input bit slow);
      nGot = 0;
      txReady <= 1'b1;
      repeat (40) begin
         @(posedge sys_clk);
         if (txValid && txReady && nGot < 9) begin
            got[nGot] = txData;
            nGot++;
            if (txLast) break;
         end
         txReady <= slow ? ~txReady : 1'b1;
      end
      txReady <= 1'b0;
   endtask
endmodule

// File: dv/test_status_read_responder.sv
// self-checking testbench of the status read responder
`timescale 1ns/1ps
`include "srr_consts.svh"

module test_status_read_responder;
   logic sys_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00, hdrPid, rxData, txData;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic pready, pslverr, hdrValid, rxValid, rxLast, txReady, txValid;
   logic txLast, e, seen, safeMoveStart, safeMoveRequest = 0;
   logic safeMoveIgnore = 0, externalSwitchState = 1, fullDutyFlag = 1;
   logic [17:0] flagCause = 18'h0;
   logic [2:0] motionState = 3'b110;
   logic [1:0] temperatureInfo = 2'b10;
   logic [15:0] actualPosition = 16'h1234, targetPosition = 16'hBEEF;
   logic [79:0] otpBytes = 80'h9988_7766_5544_3322_1100;
   logic backemfFullDutyFlag = 0, backemfCoil = 1;
   logic [4:0] backemfValue = 5'h15;
   logic [10:0] safeMoveTarget;
   int errors = 0, compares = 0;
   always #4 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (safeMoveStart) seen <= 1'b1;
   srr_status_read_responder dut (.sys_clk, .rstn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .hdrValid,
      .hdrPid, .rxValid, .rxData, .rxLast, .txReady, .txValid, .txData,
      .txLast, .flagCause, .motionState, .externalSwitchState,
      .temperatureInfo, .fullDutyFlag, .actualPosition, .targetPosition,
      .otpBytes, .backemfFullDutyFlag, .backemfCoil, .backemfValue,
      .safeMoveRequest, .safeMoveIgnore, .safeMoveStart, .safeMoveTarget);
   srr_lin_master m (.sys_clk, .txValid, .txData, .txLast, .hdrValid,
      .hdrPid, .rxValid, .rxData, .rxLast, .txReady);
   // ----------------------------------------------------------
   // shared helpers
   // ----------------------------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      compares++;
      if (g !== x) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   // idle cycle first so no strobe is driven twice in one step
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge sys_clk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge sys_clk) penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   function automatic logic [7:0] pidOf(input logic [5:0] i);
      return {~(i[1]^i[3]^i[4]^i[5]), i[0]^i[1]^i[2]^i[4], i};
   endfunction
   // inverted sum with end-around carry over id and data
   function automatic logic [7:0] csum(input logic [7:0] p,
                                      input logic [63:0] d, input int n);
      logic [8:0] s;
      s = {1'b0, p};
      for (int i = 0; i < n; i++) begin
         s = {1'b0, s[7:0]} + d[8*i +: 8];
         s = s[7:0] + s[8];
      end
      return ~s[7:0];
   endfunction
   task automatic rsp(input logic [5:0] id, input int n,
                      input logic [63:0] x, input bit slow);
      m.send(pidOf(id), 16'h0, 0);
      m.collect(slow);
      chk(32'(m.nGot), 32'(n + 1));
      for (int i = 0; i < n; i++) chk(m.got[i], x[8*(n-1-i) +: 8]);
      chk(m.got[n], csum(pidOf(id), x, n));
   endtask
   task automatic flags(input logic [17:0] x);
      apb(1'b0, `SRR_A_FLAGS, 32'h0);
      chk(r, {14'h0, x});
   endtask
   task automatic cmd(input logic [5:0] id, input logic [15:0] b,
                      input int n, input logic x);
      seen = 1'b0;
      m.send(pidOf(id), b, n);
      repeat (3) @(posedge sys_clk);
      chk({seen, safeMoveTarget}, {x, 11'h5A3});
   endtask
   // ----------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------
   task automatic t_regs();
      apb(1'b1, `SRR_A_CFG0, 32'hFFFF_A5C3);
      apb(1'b1, `SRR_A_CFG1, 32'h0005_B621);
      apb(1'b1, `SRR_A_CFG2, 32'h000D_A335);
      apb(1'b1, `SRR_A_CFG3, 32'h0000_0159);
      apb(1'b0, `SRR_A_CFG0, 32'h0);
      chk(r, 32'h0000_A5C3);
      apb(1'b0, 8'h14, 32'h0);
      chk({r[30:0], e}, 32'h1);
   endtask
   // all flags raised, thermal warning cause kept live
   task automatic t_full();
      @(posedge sys_clk) flagCause <= '1;
      @(posedge sys_clk) flagCause <= 18'h00001;
      rsp(7, 8, 64'h35C3_A521_B65F_DFFE, 0);
      flags(18'h0C001);
      rsp(7, 8, 64'hB534_12EF_BEA3_A5F9, 1);
      flags(18'h00001);
   endtask
   // short-caused defect must survive the quick read
   task automatic t_quick();
      @(posedge sys_clk) {flagCause, externalSwitchState} <= '1;
      temperatureInfo <= 2'b01;
      @(posedge sys_clk) {flagCause, externalSwitchState} <= '0;
      rsp(9, 1, 64'h7D, 0);
      flags(18'h2FFC0);
      rsp(9, 1, 64'h21, 1);
   endtask
   task automatic t_otp_bemf();
      rsp(7, 8, 64'h35C3_A521_B65F_D921, 0);
      rsp(8, 8, 64'h0011_2233_4488_9977, 0);
      rsp(7, 8, 64'h35C3_A521_B650_D001, 1);
      apb(1'b1, `SRR_A_CFG2, 32'h0005_A335);
      rsp(8, 8, 64'h0011_2233_4455_6677, 1);
      rsp(10, 1, 64'hB5, 0);
      @(posedge sys_clk) {backemfFullDutyFlag, backemfCoil} <= 2'b10;
      backemfValue <= 5'h0A;
      rsp(10, 1, 64'hCA, 0);
   endtask
   task automatic t_safe(input logic ign, input logic x);
      seen = 1'b0;
      @(posedge sys_clk) {safeMoveRequest, safeMoveIgnore} <= {1'b1, ign};
      @(posedge sys_clk) safeMoveRequest <= 1'b0;
      repeat (3) @(posedge sys_clk);
      safeMoveIgnore <= 1'b0;
      chk({31'h0, seen}, {31'h0, x});
   endtask
   task automatic end_sim();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge sys_clk);
      rstn <= 1'b1;
      t_regs();
      t_full();
      t_quick();
      t_otp_bemf();
      cmd(1, 16'h3504, 2, 1'b1);
      cmd(1, 16'h7F04, 2, 1'b1);
      cmd(1, 16'h3604, 2, 1'b0);
      cmd(2, 16'h0400, 1, 1'b1);
      cmd(1, 16'h3505, 2, 1'b0);
      t_safe(1'b1, 1'b0);
      t_safe(1'b0, 1'b1);
      end_sim();
   end
   initial begin
      #100000;
      errors++;
      end_sim();
   end
endmodule

bind srr_status_read_responder srr_monitor mon (.sys_clk, .rstn, .psel,
   .penable, .pready, .pslverr, .hdrValid, .txReady, .txValid, .txLast,
   .hdrPid, .txData, .safeMoveRequest, .safeMoveIgnore, .safeMoveStart);
